// ===== rtl/rsc_pkg.sv
package rsc_pkg;
  // register map
  localparam logic [5:0] RSC_ADDR_STRENGTH = 6'h22;
  localparam logic [5:0] RSC_ADDR_CD_FORCE = 6'h2F;
  // command byte fields
  localparam int RSC_CMD_DIR_BIT = 7;
  localparam int RSC_CMD_INC_BIT = 6;
  // strength and carrier-detect force register fields
  localparam int RSC_VALID_BIT = 5;
  localparam int RSC_LEVEL_W = 5;
  localparam int RSC_FORCE_BIT = 7;
  localparam logic [7:0] RSC_CD_RESET = 8'h00;
  localparam logic [7:0] RSC_ZERO_BYTE = 8'h00;
  // carrier qualification time
  localparam int RSC_CLK_HZ = 40000000;
  localparam int RSC_QUAL_US = 50;
  localparam int RSC_QUAL_CYC = (RSC_QUAL_US * (RSC_CLK_HZ / 1000000)) + 1;
  localparam int RSC_QUAL_W = 12;
  localparam logic [RSC_QUAL_W-1:0] RSC_QUAL_LAST = RSC_QUAL_W'(RSC_QUAL_CYC - 1);
  localparam logic [RSC_QUAL_W-1:0] RSC_QUAL_ZERO = 12'h000;

  typedef enum logic [3:0] {
    RSC_IDLE = 4'b0001,
    RSC_QUAL = 4'b0010,
    RSC_CONV = 4'b0100,
    RSC_HALT = 4'b1000
  } rsc_state_t;

  typedef struct packed {
    logic valid;
    logic [RSC_LEVEL_W-1:0] level;
  } rsc_result_t;

  typedef struct packed {
    logic write;
    logic inc;
    logic [5:0] addr;
  } rsc_cmd_t;
endpackage

// ===== rtl/rsc_spi_slave.sv
`timescale 1ns/100ps
module rsc_spi_slave (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  output rsc_pkg::rsc_cmd_t cmd,
  output logic wr_stb,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  import rsc_pkg::*;
  logic sck_q, have_cmd_q, have_cmd_d, wr_stb_q, wr_stb_d;
  logic step_q, step_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, wd_q, wd_d;
  rsc_cmd_t cmd_q, cmd_d;
  logic rise, fall;
  assign rise = sck & ~sck_q & ~ss_n;
  assign fall = ~sck & sck_q & ~ss_n;

  // mode 0: sample on rising, shift out on falling
  always_comb begin
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    cmd_d = cmd_q;
    have_cmd_d = have_cmd_q;
    wd_d = wd_q;
    wr_stb_d = 1'b0;
    step_d = 1'b0;
    if (ss_n) begin
      cnt_d = 3'h0;
      have_cmd_d = 1'b0;
    end else begin
      // address steps a cycle late so the write strobe still sees the byte's own address
      if (step_q) begin
        cmd_d.addr = cmd_q.addr + 6'h01;
      end
      if (rise) begin
        sh_d = {sh_q[6:0], mosi};
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          if (!have_cmd_q) begin
            cmd_d = rsc_cmd_t'({sh_q[6:0], mosi});
            have_cmd_d = 1'b1;
          end else begin
            wd_d = {sh_q[6:0], mosi};
            wr_stb_d = cmd_q.write;
            step_d = cmd_q.inc;
          end
        end
      end
      // load a new read byte after each completed byte, once address is known
      if (fall) begin
        if (cnt_q == 3'h0) begin
          tx_d = rd_data;
        end else begin
          tx_d = {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_q <= 1'b0;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      cmd_q <= '0;
      have_cmd_q <= 1'b0;
      wd_q <= 8'h00;
      wr_stb_q <= 1'b0;
      step_q <= 1'b0;
    end else begin
      sck_q <= sck;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      cmd_q <= cmd_d;
      have_cmd_q <= have_cmd_d;
      wd_q <= wd_d;
      wr_stb_q <= wr_stb_d;
      step_q <= step_d;
    end
  end

  assign miso = tx_q[7];
  assign miso_oe = ~ss_n;
  assign cmd = cmd_q;
  assign wr_stb = wr_stb_q;
  assign wr_data = wd_q;
endmodule

// ===== rtl/rsc_top.sv
`timescale 1ns/100ps
module rsc_top #(
  parameter bit HAS_RX = 1'b1
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic SCK,
  input wire logic SS_N,
  input wire logic MOSI,
  output logic MISO,
  output logic MISO_OE,
  input wire logic RX_EN,
  input wire logic CARRIER,
  output logic ADC_START,
  input wire logic ADC_DONE,
  input wire logic [4:0] ADC_LEVEL,
  output rsc_pkg::rsc_result_t RESULT
);
  import rsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  rsc_cmd_t cmd;
  logic wr_stb;
  logic [7:0] wr_data, rd_data;

  rsc_spi_slave u_spi (
    .clk(CLOCK),
    .arst_n(ARST_N),
    .sck(SCK),
    .ss_n(SS_N),
    .mosi(MOSI),
    .miso(MISO),
    .miso_oe(MISO_OE),
    .cmd(cmd),
    .wr_stb(wr_stb),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] cd_q, cd_d;
  rsc_state_t st_q, st_d;
  logic [RSC_QUAL_W-1:0] cnt_q, cnt_d;
  rsc_result_t res_q, res_d;
  logic rx_q, start_q, start_d, detect;

  always_comb begin
    cd_d = cd_q;
    if (wr_stb && cmd.addr == RSC_ADDR_CD_FORCE) begin
      cd_d = wr_data;
    end
  end

  // forced detect stands in for a real carrier
  assign detect = CARRIER | cd_q[RSC_FORCE_BIT];

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    res_d = res_q;
    start_d = 1'b0;
    if (!HAS_RX || !RX_EN) begin
      // transmit-only variant never measures; receive off sends the machine to idle, except that hold stays in hold
      if (!HAS_RX) begin
        st_d = RSC_IDLE;
        res_d = '0;
      end else if (st_q != RSC_HALT) begin
        st_d = RSC_IDLE;
      end
      cnt_d = RSC_QUAL_ZERO;
    end else if (!rx_q) begin
      st_d = RSC_IDLE;
      res_d.valid = 1'b0;
      cnt_d = RSC_QUAL_ZERO;
    end else begin
      unique case (st_q)
        RSC_IDLE: begin
          cnt_d = RSC_QUAL_ZERO;
          if (detect) begin
            st_d = RSC_QUAL;
          end
        end
        RSC_QUAL: begin
          if (!detect) begin
            st_d = RSC_IDLE;
          end else if (cnt_q == RSC_QUAL_LAST) begin
            st_d = RSC_CONV;
            start_d = 1'b1;
          end else begin
            cnt_d = cnt_q + 12'h001;
          end
        end
        RSC_CONV: begin
          if (ADC_DONE) begin
            res_d.level = ADC_LEVEL;
            res_d.valid = 1'b1;
            st_d = RSC_HALT;
          end
        end
        RSC_HALT: begin
          st_d = RSC_HALT;
        end
        default: st_d = RSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cd_q <= RSC_CD_RESET;
    end else begin
      cd_q <= cd_d;
    end
  end

  // receive enable is kept one cycle so a fresh enable shows up as an edge
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_q <= 1'b0;
    end else begin
      rx_q <= RX_EN;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= RSC_IDLE;
      cnt_q <= RSC_QUAL_ZERO;
      res_q <= '0;
      start_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      start_q <= start_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    unique case (cmd.addr)
      RSC_ADDR_STRENGTH: rd_data = {2'b00, res_q};
      RSC_ADDR_CD_FORCE: rd_data = cd_q;
      default: rd_data = RSC_ZERO_BYTE;
    endcase
  end

  assign ADC_START = start_q;
  assign RESULT = res_q;
endmodule

// ===== tb/rsc_host.sv
`timescale 1ns/100ps
module rsc_host (
  input wire logic clk,
  input wire logic miso,
  output logic sck,
  output logic ss_n,
  output logic mosi
);
  initial begin
    {sck, ss_n, mosi} = 3'b010;
  end
  ////////////////////
  // mode 0, three clocks a half period: above the slave's two-clock minimum
  task automatic access(input logic [15:0] f, output logic [7:0] rd);
    ss_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = f[i];
      repeat (3) @(negedge clk);
      sck = 1'b1;
      rd = {rd[6:0], miso};
      repeat (3) @(negedge clk);
      sck = 1'b0;
    end
    repeat (3) @(negedge clk);
    ss_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
endmodule

// ===== tb/rsc_top_props.sv
`timescale 1ns/100ps
module rsc_top_props (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic SS_N,
  input wire logic MISO_OE,
  input wire logic RX_EN,
  input wire logic ADC_START,
  input wire logic ADC_DONE,
  input wire logic [4:0] ADC_LEVEL,
  input wire rsc_pkg::rsc_result_t RESULT
);
  logic [11:0] run_q;
  logic rx_q, done_q;
  // saturating, so a long receive period never wraps below the limit
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      {run_q, rx_q, done_q} <= '0;
    end else begin
      run_q <= RX_EN ? run_q + 12'(run_q != 12'hFFF) : 12'h000;
      rx_q <= RX_EN;
      done_q <= ADC_START | (done_q & !(RX_EN & !rx_q));
    end
  end
  ////////////////////
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  a_qual_time: assert property (ADC_START |-> run_q > 12'h7D0) else $error("early start");
  a_hold_once: assert property (ADC_START |-> !done_q) else $error("second start");
  a_one_pulse: assert property (ADC_START |=> !ADC_START) else $error("long start");
  a_level_copy: assert property (ADC_DONE |=> RESULT.level == $past(ADC_LEVEL)) else $error("level");
  a_valid_set: assert property (ADC_DONE |=> RESULT.valid) else $error("no valid");
  a_valid_why: assert property ($rose(RESULT.valid) |-> $past(ADC_DONE)) else $error("stray valid");
  a_rx_clear: assert property (RX_EN && !rx_q |-> ##[1:2] !RESULT.valid) else $error("valid kept");
  a_oe_select: assert property (MISO_OE == !SS_N) else $error("enable");
  cover property (ADC_START);
  cover property (RX_EN && !rx_q && done_q);
  cover property (!SS_N);
endmodule
bind rsc_top rsc_top_props rsc_top_props_i (
  .CLOCK(CLOCK),
  .ARST_N(ARST_N),
  .SS_N(SS_N),
  .MISO_OE(MISO_OE),
  .RX_EN(RX_EN),
  .ADC_START(ADC_START),
  .ADC_DONE(ADC_DONE),
  .ADC_LEVEL(ADC_LEVEL),
  .RESULT(RESULT)
);

// ===== tb/tb_rsc_top.sv
`timescale 1ns/100ps
module tb_rsc_top;
  import rsc_pkg::*;
  logic CLOCK = 1'b0, ARST_N = 1'b0, RX_EN = 1'b0, CARRIER = 1'b0, ADC_DONE = 1'b0;
  logic [4:0] ADC_LEVEL = 5'h00;
  logic SCK, SS_N, MOSI, MISO, MISO_OE, ADC_START;
  logic [7:0] rd;
  rsc_result_t RESULT;
  // transmit-only copy: shares every input except ADC_DONE, must never measure
  logic MISO_TX, MISO_OE_TX, ADC_START_TX;
  logic ADC_DONE_TX = 1'b0, tx_started = 1'b0;
  rsc_result_t RESULT_TX;
  int n_mismatch = 0, tests_run = 0, n;
  rsc_top rsc_top_i (
    .CLOCK(CLOCK),
    .ARST_N(ARST_N),
    .SCK(SCK),
    .SS_N(SS_N),
    .MOSI(MOSI),
    .MISO(MISO),
    .MISO_OE(MISO_OE),
    .RX_EN(RX_EN),
    .CARRIER(CARRIER),
    .ADC_START(ADC_START),
    .ADC_DONE(ADC_DONE),
    .ADC_LEVEL(ADC_LEVEL),
    .RESULT(RESULT)
  );
  rsc_top #(.HAS_RX(1'b0)) rsc_top_tx_i (
    .CLOCK(CLOCK),
    .ARST_N(ARST_N),
    .SCK(SCK),
    .SS_N(SS_N),
    .MOSI(MOSI),
    .MISO(MISO_TX),
    .MISO_OE(MISO_OE_TX),
    .RX_EN(RX_EN),
    .CARRIER(CARRIER),
    .ADC_START(ADC_START_TX),
    .ADC_DONE(ADC_DONE_TX),
    .ADC_LEVEL(ADC_LEVEL),
    .RESULT(RESULT_TX)
  );
  rsc_host rsc_host_i (.clk(CLOCK), .miso(MISO), .sck(SCK), .ss_n(SS_N), .mosi(MOSI));
  initial forever #12.5 CLOCK = ~CLOCK;
  // converter answers half a cycle after each start
  always @(negedge CLOCK) begin
    ADC_DONE <= ADC_START;
    ADC_DONE_TX <= ADC_START_TX;
    if (ADC_START_TX) tx_started <= 1'b1;
  end
  ////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic spi(input logic [15:0] f, input logic [7:0] exp);
    rsc_host_i.access(f, rd);
    if (!f[15]) check(rd, exp);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge CLOCK);
  endtask
  task automatic wait_start();
    for (n = 0; ADC_START !== 1'b1; n++) begin
      if (n > 3000) begin
        n_mismatch++;
        report_and_stop();
      end
      cyc(1);
    end
  endtask
  ////////////////////
  task automatic test_carrier();
    check({2'b00, RESULT}, 8'h00);
    spi(16'h2F00, RSC_CD_RESET);
    spi(16'hA23F, 8'h00);
    spi(16'h2200, 8'h00);
    {RX_EN, CARRIER, ADC_LEVEL} = 7'h7D;
    // a drop mid-qualification must restart the count
    cyc(1000);
    CARRIER = 1'b0;
    cyc(1);
    CARRIER = 1'b1;
    wait_start();
    check(8'(n >= RSC_QUAL_CYC && n < RSC_QUAL_CYC + 3), 8'h01);
    cyc(100);
    check({2'b00, RESULT}, 8'h3D);
    // a second conversion in hold would bring in this new level
    ADC_LEVEL = 5'h02;
    cyc(2100);
    check({2'b00, RESULT}, 8'h3D);
    RX_EN = 1'b0;
    cyc(5);
    spi(16'h2200, 8'h3D);
    RX_EN = 1'b1;
    cyc(3);
    check({7'h00, RESULT.valid}, 8'h00);
    {RX_EN, CARRIER} = 2'b00;
    $display("carrier test done");
  endtask
  task automatic test_quiet();
    // level bits keep the previous result; only the flag is cleared
    logic [4:0] last = 5'h1D;
    for (int k = 0; k < 20; k++) begin
      ADC_LEVEL = 5'(k % 11);
      RX_EN = 1'b1;
      cyc(3);
      spi(16'h2200, {3'b000, last});
      spi(16'hAF80, 8'h00);
      spi(16'h2F00, 8'h80);
      wait_start();
      cyc(2);
      spi(16'h2200, 8'(32 + k % 11));
      spi(16'hAF00, 8'h00);
      last = 5'(k % 11);
      RX_EN = 1'b0;
      cyc(3);
    end
    check({1'b0, tx_started, RESULT_TX}, 8'h00);
    $display("quiet test done");
  endtask
  initial begin
    cyc(10);
    ARST_N = 1'b1;
    cyc(2);
    test_carrier();
    test_quiet();
    report_and_stop();
  end
endmodule
